/* src/usb_ep_cfg_pkg.sv */
// Purpose: Shared constants and types for the endpoint buffer setup block
// Assumes: APB with 32-bit data, one word per register
// Notes:   Offsets are byte addresses
package usb_ep_cfg_pkg;
   // ==========================================================
   // Bus shape
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   // ==========================================================
   // Register offsets
   localparam logic [7:0] OFS_IN_PIPE = 8'h00;
   localparam logic [7:0] OFS_OUT_PIPE = 8'h04;
   localparam logic [7:0] OFS_SIZE_CTL = 8'h08;
   localparam logic [7:0] OFS_EP_SEL = 8'h0c;
   localparam logic [7:0] OFS_TX_DATA = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;
   // ==========================================================
   // Field positions
   localparam int BIT_RELOAD = 0;
   localparam int BIT_TOGGLE = 0;
   localparam int EP_EN_LSB = 1;
   localparam int EP_EN_MSB = 3;
   localparam int BANK_LSB = 0;
   localparam int BANK_MSB = 1;
   localparam int SEL_MSB = 3;
   localparam int STAT_BUSY = 0;
   localparam int STAT_ERR = 1;
   localparam int STAT_FULL = 2;
   localparam int STAT_EMPTY = 3;
   localparam int STAT_SEL_OK = 4;
   localparam int STAT_CAP_LSB = 8;
   localparam int STAT_CAP_MSB = 14;
   // ==========================================================
   // Reset values
   localparam logic [2:0] RST_EP_EN = 3'h0;
   localparam logic RST_TOGGLE = 1'b0;
   localparam logic [7:0] RST_SIZE_CTL = 8'h00;
   localparam logic [3:0] RST_EP_SEL = 4'h0;
   // ==========================================================
   // Buffer geometry
   localparam int FIFO_DEPTH = 32;
   localparam int FIFO_WIDTH = 10;
   localparam logic [6:0] EP0_BYTES = 7'h08;
   localparam logic [7:0] CFG_BANK_BYTES = 8'h40;
   localparam logic [1:0] LAST_EP = 2'h3;
   // ==========================================================
   // Types
   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_SUM = 2'b01,
      ST_DONE = 2'b10
   } rebuild_state_t;
   // ==========================================================
   // Size code to bytes
   function automatic logic [6:0] size_bytes(input logic [1:0] code);
      case (code)
         2'h0: size_bytes = 7'h08;
         2'h1: size_bytes = 7'h10;
         2'h2: size_bytes = 7'h20;
         default: size_bytes = 7'h40;
      endcase
   endfunction
endpackage

/* src/usb_ep_fifo.sv */
// Purpose: Synchronous FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   Flush empties it in one cycle
`timescale 1ns/1ns
module usb_ep_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 32
) (
   input wire logic clk_i,              // Clock
   input wire logic rst_i,              // Async reset, high
   input wire logic flush_i,            // Drop all content
   input wire logic [WIDTH-1:0] in_data_i, // Write word
   input wire logic in_valid_i,         // Write request
   output logic in_ready_o,             // Space free
   output logic [WIDTH-1:0] out_data_o, // Head word
   output logic out_valid_o,            // Not empty
   input wire logic out_ready_i         // Drain accepts
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr_r;
   logic [AW:0] rd_ptr_r;
   logic push;
   logic pop;

   assign out_valid_o = (wr_ptr_r != rd_ptr_r);
   assign in_ready_o = (wr_ptr_r[AW-1:0] != rd_ptr_r[AW-1:0]) ||
                       (wr_ptr_r[AW] == rd_ptr_r[AW]);
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;
   assign out_data_o = mem[rd_ptr_r[AW-1:0]];

   always_ff @(posedge clk_i)
   begin
      if (push)
      begin
         mem[wr_ptr_r[AW-1:0]] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end
      else if (flush_i)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (pop)
         begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
      end
   end
endmodule

/* src/usb_endpoint_fifo_config.sv */
// Purpose: Endpoint buffer setup registers of a full-speed USB device
// Assumes: Token inputs come from engine logic on the same clock
// Notes:   APB slave, one wait state, data writes stall when full
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ns
module usb_endpoint_fifo_config (
   input wire logic REF_CLK_I,                              // 250 MHz
   input wire logic RESET_I,                                // Async, high
   input wire logic PSEL_I,                                 // APB select
   input wire logic PENABLE_I,                              // APB enable
   input wire logic PWRITE_I,                               // APB write
   input wire logic [usb_ep_cfg_pkg::ADDR_W-1:0] PADDR_I,   // APB address
   input wire logic [usb_ep_cfg_pkg::DATA_W-1:0] PWDATA_I,  // APB wdata
   output logic [usb_ep_cfg_pkg::DATA_W-1:0] PRDATA_O,      // APB rdata
   output logic PREADY_O,                                   // APB ready
   output logic PSLVERR_O,                                  // APB error
   input wire logic TOKEN_VALID_I,                          // Token seen
   input wire logic TOKEN_IS_IN_I,                          // Token is IN
   input wire logic [1:0] TOKEN_EP_I,                       // Token ep
   output logic TOKEN_ACCEPT_O,                             // Serve token
   output logic TOKEN_IGNORE_O,                             // Drop token
   output logic LAYOUT_BUSY_O,                              // Rebuilding
   output logic LAYOUT_ERR_O,                               // Bad layout
   output logic [2:0] LAYOUT_IN_EN_O,                       // Ep3..1 in
   output logic [2:0] LAYOUT_OUT_EN_O,                      // Ep3..1 out
   output logic [7:0] LAYOUT_SIZE_O,                        // Size codes
   output logic [1:0] BANK_IN_O,                            // Bank is in
   output logic DATA_TOGGLE_O,                              // Toggle
   output logic [3:0] EP_SELECT_O,                          // Select bits
   output logic [7:0] TX_DATA_O,                            // Byte out
   output logic [1:0] TX_EP_O,                              // Byte ep
   output logic TX_VALID_O,                                 // Byte valid
   input wire logic TX_READY_I                              // Byte taken
);
   import usb_ep_cfg_pkg::*;

   // ==========================================================
   // Helpers
   function automatic logic [1:0] bank_in_map(input logic [1:0] code);
      case (code)
         2'h0: bank_in_map = 2'b01;
         2'h1: bank_in_map = 2'b00;
         2'h2: bank_in_map = 2'b11;
         default: bank_in_map = 2'b10;
      endcase
   endfunction

   function automatic logic [1:0] size_code(input logic [7:0] ctl,
                                            input logic [1:0] ep);
      case (ep)
         2'h1: size_code = ctl[3:2];
         2'h2: size_code = ctl[5:4];
         2'h3: size_code = ctl[7:6];
         default: size_code = 2'h0;
      endcase
   endfunction

   // ==========================================================
   // Declarations
   logic reload_r, toggle_r, pready_r, pslverr_r, err_nxt, access, done;
   logic wr_done, stall, reload_wr, busy_r, lay_err_r, dir_err, sel_ok;
   logic tok_ok, fifo_in_ready, fifo_in_valid, fifo_out_valid;
   logic fifo_out_ready, tx_valid_r;
   logic [1:0] idx_r, act_bank_r, lay_bank_r, sel_ep, tx_ep_r;
   logic [2:0] in_en_r, out_en_r, act_in_r, act_out_r, lay_in_r, lay_out_r;
   logic [3:0] sel_r, ep_live;
   logic [6:0] sel_cap;
   logic [7:0] size_ctl_r, sum_r, act_size_r, lay_size_r, add_bytes;
   logic [7:0] tx_data_r;
   logic [DATA_W-1:0] prdata_r, rd_nxt;
   logic [FIFO_WIDTH-1:0] fifo_out_data;
   rebuild_state_t state_r;

   // ==========================================================
   // APB handshake
   assign access = PSEL_I & PENABLE_I;
   assign done = access & pready_r;
   assign wr_done = done & PWRITE_I & ~pslverr_r;
   assign reload_wr = wr_done & (PADDR_I == OFS_IN_PIPE) &
                      PWDATA_I[BIT_RELOAD];
   assign stall = PWRITE_I & (PADDR_I == OFS_TX_DATA) & sel_ok &
                  (~fifo_in_ready | busy_r);

   always_ff @(posedge REF_CLK_I or posedge RESET_I)
   begin
      if (RESET_I)
      begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= '0;
      end
      else
      begin
         pready_r <= access & ~pready_r & ~stall;
         if (access & ~pready_r & ~stall)
         begin
            prdata_r <= rd_nxt;
            pslverr_r <= err_nxt;
         end
         else if (done)
         begin
            pslverr_r <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Read mux and decode errors
   always_comb
   begin
      rd_nxt = '0;
      err_nxt = 1'b0;
      case (PADDR_I)
         OFS_IN_PIPE: rd_nxt = {28'h0, in_en_r, reload_r};
         OFS_OUT_PIPE: rd_nxt = {28'h0, out_en_r, toggle_r};
         OFS_SIZE_CTL: rd_nxt = {24'h0, size_ctl_r};
         OFS_EP_SEL: rd_nxt = {28'h0, sel_r};
         OFS_TX_DATA: err_nxt = PWRITE_I & ~sel_ok;
         OFS_STATUS:
         begin
            rd_nxt[STAT_BUSY] = busy_r;
            rd_nxt[STAT_ERR] = lay_err_r;
            rd_nxt[STAT_FULL] = ~fifo_in_ready;
            rd_nxt[STAT_EMPTY] = ~fifo_out_valid;
            rd_nxt[STAT_SEL_OK] = sel_ok;
            rd_nxt[STAT_CAP_MSB:STAT_CAP_LSB] = sel_cap;
            err_nxt = PWRITE_I;
         end
         default: err_nxt = 1'b1;
      endcase
   end

   // ==========================================================
   // Pipe enables, toggle, size and select registers
   always_ff @(posedge REF_CLK_I or posedge RESET_I)
   begin
      if (RESET_I)
      begin
         in_en_r <= RST_EP_EN;
         out_en_r <= RST_EP_EN;
         toggle_r <= RST_TOGGLE;
         size_ctl_r <= RST_SIZE_CTL;
         sel_r <= RST_EP_SEL;
      end
      else if (wr_done)
      begin
         case (PADDR_I)
            OFS_IN_PIPE: in_en_r <= PWDATA_I[EP_EN_MSB:EP_EN_LSB];
            OFS_OUT_PIPE:
            begin
               out_en_r <= PWDATA_I[EP_EN_MSB:EP_EN_LSB];
               toggle_r <= PWDATA_I[BIT_TOGGLE];
            end
            OFS_SIZE_CTL: size_ctl_r <= PWDATA_I[7:0];
            OFS_EP_SEL: sel_r <= PWDATA_I[SEL_MSB:0];
            default: ;
         endcase
      end
   end

   // ==========================================================
   // Reload bit: a new write wins over the self clear
   always_ff @(posedge REF_CLK_I or posedge RESET_I)
   begin
      if (RESET_I)
      begin
         reload_r <= 1'b0;
      end
      else if (reload_wr)
      begin
         reload_r <= 1'b1;
      end
      else if (state_r == ST_DONE)
      begin
         reload_r <= 1'b0;
      end
   end

   // ==========================================================
   // Layout rebuild sequence
   assign add_bytes = ((act_in_r[idx_r - 2'h1] | act_out_r[idx_r - 2'h1]) ?
                      {1'b0, size_bytes(size_code(act_size_r, idx_r))} :
                      8'h00);
   assign dir_err = ((|act_in_r) & ~(|bank_in_map(act_bank_r))) |
                    ((|act_out_r) & (&bank_in_map(act_bank_r)));

   always_ff @(posedge REF_CLK_I or posedge RESET_I)
   begin
      if (RESET_I)
      begin
         state_r <= ST_IDLE;
         idx_r <= 2'h1;
         sum_r <= 8'h00;
         act_in_r <= RST_EP_EN;
         act_out_r <= RST_EP_EN;
         act_size_r <= RST_SIZE_CTL;
         act_bank_r <= 2'h0;
         busy_r <= 1'b0;
      end
      else if (reload_wr)
      begin
         state_r <= ST_SUM;
         idx_r <= 2'h1;
         sum_r <= 8'h00;
         act_in_r <= PWDATA_I[EP_EN_MSB:EP_EN_LSB];
         act_out_r <= out_en_r;
         act_size_r <= size_ctl_r;
         act_bank_r <= size_ctl_r[BANK_MSB:BANK_LSB];
         busy_r <= 1'b1;
      end
      else
      begin
         case (state_r)
            ST_IDLE: busy_r <= 1'b0;
            ST_SUM:
            begin
               sum_r <= sum_r + add_bytes;
               idx_r <= idx_r + 2'h1;
               if (idx_r == LAST_EP)
               begin
                  state_r <= ST_DONE;
               end
            end
            ST_DONE:
            begin
               state_r <= ST_IDLE;
               busy_r <= 1'b0;
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Published layout
   always_ff @(posedge REF_CLK_I or posedge RESET_I)
   begin
      if (RESET_I)
      begin
         lay_err_r <= 1'b0;
         lay_in_r <= RST_EP_EN;
         lay_out_r <= RST_EP_EN;
         lay_size_r <= RST_SIZE_CTL;
         lay_bank_r <= 2'b01;
      end
      else if (state_r == ST_DONE && !reload_wr)
      begin
         lay_err_r <= (sum_r > CFG_BANK_BYTES) | dir_err;
         lay_in_r <= act_in_r;
         lay_out_r <= act_out_r;
         lay_size_r <= act_size_r;
         lay_bank_r <= bank_in_map(act_bank_r);
      end
   end

   // ==========================================================
   // Endpoint selection
   assign ep_live = {lay_in_r | lay_out_r, 1'b1};

   always_comb
   begin
      sel_ep = 2'h0;
      sel_ok = 1'b0;
      for (int k = 3; k >= 0; k--)
      begin
         if (sel_r[k] & ep_live[k])
         begin
            sel_ep = 2'(k);
            sel_ok = 1'b1;
         end
      end
   end

   assign sel_cap = (sel_ep == 2'h0) ? EP0_BYTES :
                    size_bytes(size_code(lay_size_r, sel_ep));

   // ==========================================================
   // Token screening; enables are never touched here
   assign tok_ok = (TOKEN_EP_I == 2'h0) ||
                   (TOKEN_IS_IN_I ? lay_in_r[TOKEN_EP_I - 2'h1] :
                                    lay_out_r[TOKEN_EP_I - 2'h1]);

   always_ff @(posedge REF_CLK_I or posedge RESET_I)
   begin
      if (RESET_I)
      begin
         TOKEN_ACCEPT_O <= 1'b0;
         TOKEN_IGNORE_O <= 1'b0;
      end
      else
      begin
         TOKEN_ACCEPT_O <= TOKEN_VALID_I & tok_ok & ~busy_r;
         TOKEN_IGNORE_O <= TOKEN_VALID_I & (~tok_ok | busy_r);
      end
   end

   // ==========================================================
   // Transmit path
   assign fifo_in_valid = wr_done & (PADDR_I == OFS_TX_DATA);
   assign fifo_out_ready = ~tx_valid_r | TX_READY_I;

   usb_ep_fifo #(
      .WIDTH(FIFO_WIDTH),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_i(REF_CLK_I),
      .rst_i(RESET_I),
      .flush_i(reload_wr),
      .in_data_i({sel_ep, PWDATA_I[7:0]}),
      .in_valid_i(fifo_in_valid),
      .in_ready_o(fifo_in_ready),
      .out_data_o(fifo_out_data),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(fifo_out_ready)
   );

   always_ff @(posedge REF_CLK_I or posedge RESET_I)
   begin
      if (RESET_I)
      begin
         tx_valid_r <= 1'b0;
         tx_data_r <= 8'h00;
         tx_ep_r <= 2'h0;
      end
      else if (reload_wr)
      begin
         tx_valid_r <= 1'b0;
      end
      else if (fifo_out_ready)
      begin
         tx_valid_r <= fifo_out_valid;
         if (fifo_out_valid)
         begin
            tx_data_r <= fifo_out_data[7:0];
            tx_ep_r <= fifo_out_data[9:8];
         end
      end
   end

   // ==========================================================
   // Outputs
   assign PRDATA_O = prdata_r;
   assign PREADY_O = pready_r;
   assign PSLVERR_O = pslverr_r;
   assign LAYOUT_BUSY_O = busy_r;
   assign LAYOUT_ERR_O = lay_err_r;
   assign LAYOUT_IN_EN_O = lay_in_r;
   assign LAYOUT_OUT_EN_O = lay_out_r;
   assign LAYOUT_SIZE_O = lay_size_r;
   assign BANK_IN_O = lay_bank_r;
   assign DATA_TOGGLE_O = toggle_r;
   assign EP_SELECT_O = sel_r;
   assign TX_DATA_O = tx_data_r;
   assign TX_EP_O = tx_ep_r;
   assign TX_VALID_O = tx_valid_r;
endmodule

/* verification/usb_ep_cfg_checker.sv */
// Purpose: Port assertions for the endpoint buffer setup block
// Assumes: One clock domain, bound to the top module
// Notes:   Layout outputs move only as a rebuild ends
`timescale 1ns/1ns
module usb_ep_cfg_checker (
   input wire logic REF_CLK_I, // Clock
   input wire logic RESET_I, // Reset
   input wire logic PSEL_I, // Select
   input wire logic PENABLE_I, // Enable
   input wire logic PWRITE_I, // Write
   input wire logic [usb_ep_cfg_pkg::ADDR_W-1:0] PADDR_I, // Address
   input wire logic [usb_ep_cfg_pkg::DATA_W-1:0] PWDATA_I, // Wdata
   input wire logic [usb_ep_cfg_pkg::DATA_W-1:0] PRDATA_O, // Rdata
   input wire logic PREADY_O, // Ready
   input wire logic TOKEN_VALID_I, // Token
   input wire logic TOKEN_IS_IN_I, // IN
   input wire logic [1:0] TOKEN_EP_I, // Ep
   input wire logic TOKEN_ACCEPT_O, // Served
   input wire logic TOKEN_IGNORE_O, // Dropped
   input wire logic LAYOUT_BUSY_O, // Busy
   input wire logic [2:0] LAYOUT_IN_EN_O, // In enables
   input wire logic [2:0] LAYOUT_OUT_EN_O, // Out enables
   input wire logic [7:0] LAYOUT_SIZE_O, // Sizes
   input wire logic [1:0] BANK_IN_O, // Bank roles
   input wire logic DATA_TOGGLE_O, // Toggle
   input wire logic [3:0] EP_SELECT_O // Select
);
   import usb_ep_cfg_pkg::*;
   // ======
   // Helpers
   logic wr_w, out_wr_w, sel_wr_w, cfg_w, tok_w;
   logic [1:0] ix;
   assign wr_w = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I;
   assign out_wr_w = wr_w && PADDR_I == OFS_OUT_PIPE;
   assign sel_wr_w = wr_w && PADDR_I == OFS_EP_SEL;
   assign ix = TOKEN_EP_I - 2'h1;
   assign cfg_w = TOKEN_IS_IN_I ? LAYOUT_IN_EN_O[ix] : LAYOUT_OUT_EN_O[ix];
   assign tok_w = TOKEN_VALID_I && !LAYOUT_BUSY_O && TOKEN_EP_I != 2'h0;
   default clocking cb @(posedge REF_CLK_I);
   endclocking
   default disable iff (RESET_I);
   property p_reload;
      wr_w && PADDR_I == OFS_IN_PIPE && PWDATA_I[0] |=> LAYOUT_BUSY_O;
   endproperty
   a_reload: assert property (p_reload) else $error("no rebuild");
   property p_busy_end;
      $rose(LAYOUT_BUSY_O) |-> ##[3:6] !LAYOUT_BUSY_O;
   endproperty
   a_busy_end: assert property (p_busy_end) else $error("busy stuck");
   property p_hold;
      $changed(LAYOUT_IN_EN_O) || $changed(LAYOUT_OUT_EN_O)
         || $changed(LAYOUT_SIZE_O) |-> $past(LAYOUT_BUSY_O);
   endproperty
   a_hold: assert property (p_hold) else $error("layout moved");
   property p_ignore;
      tok_w && !cfg_w |=> TOKEN_IGNORE_O && !TOKEN_ACCEPT_O
         && $stable(LAYOUT_IN_EN_O) && $stable(LAYOUT_OUT_EN_O);
   endproperty
   a_ignore: assert property (p_ignore) else $error("bad ignore");
   property p_accept;
      tok_w && cfg_w |=> TOKEN_ACCEPT_O && !TOKEN_IGNORE_O;
   endproperty
   a_accept: assert property (p_accept) else $error("no accept");
   property p_ep0;
      TOKEN_VALID_I && !LAYOUT_BUSY_O && TOKEN_EP_I == 2'h0 |=> TOKEN_ACCEPT_O;
   endproperty
   a_ep0: assert property (p_ep0) else $error("ep0 refused");
   property p_bank;
      $fell(LAYOUT_BUSY_O)
         |-> BANK_IN_O == {LAYOUT_SIZE_O[1], ~LAYOUT_SIZE_O[0]};
   endproperty
   a_bank: assert property (p_bank) else $error("bank roles");
   property p_unused;
      PSEL_I && PREADY_O && !PWRITE_I && (PADDR_I == OFS_IN_PIPE
         || PADDR_I == OFS_OUT_PIPE || PADDR_I == OFS_EP_SEL)
         |-> PRDATA_O[31:4] == 28'h0;
   endproperty
   a_unused: assert property (p_unused) else $error("upper bits");
   property p_toggle;
      $changed(DATA_TOGGLE_O) |-> $past(out_wr_w);
   endproperty
   a_toggle: assert property (p_toggle) else $error("toggle moved");
   property p_sel;
      $changed(EP_SELECT_O) |-> $past(sel_wr_w);
   endproperty
   a_sel: assert property (p_sel) else $error("select moved");
   c_rebuild: cover property ($fell(LAYOUT_BUSY_O));
   c_ignore: cover property (TOKEN_IGNORE_O);
   c_accept: cover property (TOKEN_ACCEPT_O);
endmodule

bind usb_endpoint_fifo_config usb_ep_cfg_checker usb_ep_cfg_checker_i (
   .REF_CLK_I, .RESET_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I,
   .PWDATA_I, .PRDATA_O, .PREADY_O, .TOKEN_VALID_I, .TOKEN_IS_IN_I,
   .TOKEN_EP_I, .TOKEN_ACCEPT_O, .TOKEN_IGNORE_O, .LAYOUT_BUSY_O,
   .LAYOUT_IN_EN_O, .LAYOUT_OUT_EN_O, .LAYOUT_SIZE_O, .BANK_IN_O,
   .DATA_TOGGLE_O, .EP_SELECT_O
);

/* verification/usb_host_model.sv */
// Purpose: Bus host side, sends tokens and takes bytes
// Assumes: Same clock as the block
// Notes:   Stalls at random, or fully while stall_i
`timescale 1ns/1ns
module usb_host_model (
   input wire logic clk_i, // Clock
   input wire logic rst_i, // Reset
   input wire logic stall_i, // Hold off
   output logic tok_valid_o, // Token pulse
   output logic tok_in_o, // IN token
   output logic [1:0] tok_ep_o, // Token ep
   input wire logic tok_acc_i, // Served
   input wire logic tok_ign_i, // Dropped
   input wire logic [7:0] tx_data_i, // Byte
   input wire logic [1:0] tx_ep_i, // Byte ep
   input wire logic tx_valid_i, // Byte valid
   output logic tx_ready_o // Byte taken
);
   logic [9:0] rx_q[$];
   logic [1:0] res;
   logic [3:0] lfsr;
   initial
   begin
      tok_valid_o = 1'b0;
      tok_in_o = 1'b0;
      tok_ep_o = 2'h0;
   end
   // Idle lines show the inverse of the last token
   task automatic send_token(input logic is_in, input logic [1:0] ep);
      @(posedge clk_i);
      tok_valid_o <= 1'b1;
      tok_in_o <= is_in;
      tok_ep_o <= ep;
      @(posedge clk_i);
      tok_valid_o <= 1'b0;
      tok_in_o <= ~is_in;
      tok_ep_o <= ~ep;
      @(posedge clk_i);
      res = {tok_acc_i, tok_ign_i};
   endtask
   always @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         lfsr <= 4'h9;
         tx_ready_o <= 1'b0;
      end
      else
      begin
         lfsr <= {lfsr[2:0], lfsr[3] ^ lfsr[2]};
         tx_ready_o <= !stall_i && lfsr[0];
         if (tx_valid_i && tx_ready_o)
            rx_q.push_back({tx_ep_i, tx_data_i});
      end
   end
endmodule

/* verification/usb_endpoint_fifo_config_tb_top.sv */
// Purpose: Self-checking bench for the endpoint buffer setup block
// Assumes: One wait state APB slave
// Notes:   Random layouts from a fixed seed
`timescale 1ns/1ns
module usb_endpoint_fifo_config_tb_top;
   import usb_ep_cfg_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic stall = 1'b1;
   logic [7:0] pa = 8'h00;
   logic [31:0] pwd = 32'h0;
   logic [31:0] prd, rv;
   logic prdy, perr, ev, tv, tin, tacc, tign, busy, lerr, tog, txv, txr, tg;
   logic [1:0] tep, bank, txe;
   logic [2:0] lin, lout, ie, oe;
   logic [3:0] sel;
   logic [7:0] lsize, txd, sz;
   logic ok;
   int seed, failures, compares, cyc, n, m;
   usb_endpoint_fifo_config usb_endpoint_fifo_config_i (.REF_CLK_I(clk),
      .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
      .PADDR_I(pa), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy),
      .PSLVERR_O(perr), .TOKEN_VALID_I(tv), .TOKEN_IS_IN_I(tin),
      .TOKEN_EP_I(tep), .TOKEN_ACCEPT_O(tacc), .TOKEN_IGNORE_O(tign),
      .LAYOUT_BUSY_O(busy), .LAYOUT_ERR_O(lerr), .LAYOUT_IN_EN_O(lin),
      .LAYOUT_OUT_EN_O(lout), .LAYOUT_SIZE_O(lsize), .BANK_IN_O(bank),
      .DATA_TOGGLE_O(tog), .EP_SELECT_O(sel), .TX_DATA_O(txd),
      .TX_EP_O(txe), .TX_VALID_O(txv), .TX_READY_I(txr));
   usb_host_model usb_host_model_i (.clk_i(clk), .rst_i(rst),
      .stall_i(stall), .tok_valid_o(tv), .tok_in_o(tin), .tok_ep_o(tep),
      .tok_acc_i(tacc), .tok_ign_i(tign), .tx_data_i(txd), .tx_ep_i(txe),
      .tx_valid_i(txv), .tx_ready_o(txr));
   always #2 clk = ~clk;
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 8000)
      begin
         failures++;
         end_sim();
      end
   end
   task automatic end_sim();
      if (failures == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         failures++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      do
      begin
         @(posedge clk);
      end while (prdy !== 1'b1);
      rv = prd;
      ev = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   function automatic logic exp_err(logic [2:0] i, logic [2:0] o,
                                    logic [7:0] s);
      int sum;
      sum = 0;
      for (int k = 0; k < 3; k++)
         if (i[k] || o[k])
            sum += 8 << s[2*k+2 +: 2];
      return sum > 64 || (|i && s[1:0] == 2'h1) || (|o && s[1:0] == 2'h2);
   endfunction
   initial
   begin
      seed = 45155;
      tg = 1'b0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      for (int a = 0; a < 4; a++)
      begin
         apb(1'b0, 8'(a * 4), 32'h0);
         chk(rv, 32'h0);
      end
      chk(bank, 2'h1);
      apb(1'b0, 8'h18, 32'h0);
      chk(rv, 32'h0);
      chk(ev, 1'b1);
      apb(1'b1, OFS_STATUS, 32'h1);
      chk(ev, 1'b1);
      apb(1'b1, OFS_EP_SEL, 32'hffff_ffff);
      apb(1'b0, OFS_EP_SEL, 32'h0);
      chk(rv, 32'hf);
      chk(sel, 4'hf);
      for (int i = 0; i < 8; i++)
      begin
         ie = 3'($random(seed));
         oe = 3'($random(seed));
         sz = 8'($random(seed));
         sz[1:0] = i[1:0];
         if (i == 4)
            sz = 8'hfc;
         tg = ~tg;
         apb(1'b1, OFS_SIZE_CTL, {24'h0, sz});
         apb(1'b1, OFS_OUT_PIPE, {28'hfffffff, oe, tg});
         apb(1'b1, OFS_IN_PIPE, {28'hfffffff, ie, 1'b1});
         m = 0;
         do
         begin
            apb(1'b0, OFS_IN_PIPE, 32'h0);
            m++;
         end while (rv[0] !== 1'b0 && m < 20);
         chk(rv, {28'h0, ie, 1'b0});
         chk(tog, tg);
         chk({lin, lout, lsize}, {ie, oe, sz});
         chk(bank, {sz[1], ~sz[0]});
         chk(lerr, exp_err(ie, oe, sz));
         for (int k = 0; k < 4; k++)
         begin
            ok = k == 0 || ie[k-1] || oe[k-1];
            apb(1'b1, OFS_EP_SEL, 32'h1 << k);
            apb(1'b0, OFS_STATUS, 32'h0);
            chk(rv[STAT_SEL_OK], ok);
            if (ok)
               chk(rv[14:8], k == 0 ? 8 : 8 << sz[2*k +: 2]);
         end
         for (int k = 0; k < 8; k++)
         begin
            usb_host_model_i.send_token(k[2], k[1:0]);
            ok = k[1:0] == 0 || (k[2] ? ie[k[1:0]-1] : oe[k[1:0]-1]);
            chk(usb_host_model_i.res, {ok, ~ok});
         end
         chk({lin, lout}, {ie, oe});
      end
      apb(1'b1, OFS_EP_SEL, 32'h0);
      apb(1'b1, OFS_TX_DATA, 32'h5a);
      chk(ev, 1'b1);
      apb(1'b1, OFS_EP_SEL, 32'h1);
      n = 0;
      do
      begin
         apb(1'b1, OFS_TX_DATA, 32'(n + 8'h30));
         n++;
         apb(1'b0, OFS_STATUS, 32'h0);
      end while (rv[STAT_FULL] !== 1'b1 && n < 40);
      chk(rv[STAT_FULL], 1'b1);
      stall <= 1'b0;
      m = 0;
      while (usb_host_model_i.rx_q.size() < n && m < 1000)
      begin
         @(posedge clk);
         m++;
      end
      chk(usb_host_model_i.rx_q.size(), n);
      foreach (usb_host_model_i.rx_q[j])
         chk(usb_host_model_i.rx_q[j], {2'h0, 8'(j + 8'h30)});
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(rv[STAT_EMPTY], 1'b1);
      end_sim();
   end
endmodule
